// ===== logic/dcf_pkg.sv
// package for the dual channel fault supervisor: timing, field positions, reset values
package dcf_pkg;
   localparam int NUM_CH = 2;
   // clock and restart timer
   localparam int CLK_HZ = 25_000_000;
   localparam int RESTART_MIN_MS = 4;
   localparam int RESTART_BASE_CYC = RESTART_MIN_MS * (CLK_HZ / 1000);
   localparam int TIMER_W = 20;
   // communication watchdog, plus the restart delay select reset value
   localparam int WD_W = 25;
   localparam logic [4:0] WD_TAP_RESET = 5'h18;
   localparam logic WD_ON_RESET = 1'h1;
   localparam logic [1:0] RESTART_SEL_RESET = 2'h0;
   // status register layout, per channel fields repeat every CH_STRIDE bits
   localparam int ST_W = 8;
   localparam int CH_STRIDE = 4;
   localparam int ST1_SHORT = 0;
   localparam int ST1_HS_LIM = 1;
   localparam int ST1_LS_LIM = 2;
   localparam int ST1_COMP_OV = 3;
   localparam int ST2_MIN_OFF = 0;
   localparam int ST2_BST_UV = 1;
   localparam int ST2_THERMAL = 2;
   localparam int ST3_THERMAL_WARN = 0;
   localparam int ST3_ANALOG_UV = 1;
   localparam int ST3_POWER_CYCLE = 2;
   localparam int ST3_SPI_ERROR = 3;
   localparam int ST3_LIMP_HOME = 4;
   localparam logic [ST_W-1:0] ST12_RESET = 8'h00;
   localparam logic [ST_W-1:0] ST3_RESET = 8'h04;
   // synchroniser vector width and channel recovery states
   localparam int SY_W = 20;
   typedef enum logic [2:0] {
      CH_OFF,
      CH_RUN,
      CH_WAIT_TIMER,
      CH_WAIT_COOL,
      CH_LATCHED
   } dcf_ch_state_t;
endpackage : dcf_pkg

// ===== logic/dcf_restart_timer.sv
// restart timer for one channel: 1, 2, 4 or 8 base periods
`timescale 1ns/1ps
module dcf_restart_timer #(
   parameter int P_BASE_CYC = dcf_pkg::RESTART_BASE_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // control
   input wire logic i_start,
   input wire logic [1:0] i_sel,
   // result
   output logic o_expired
);
   localparam logic [dcf_pkg::TIMER_W-1:0] ONE = 20'h00001;
   localparam logic [dcf_pkg::TIMER_W-1:0] ZERO = 20'h00000;
   logic [dcf_pkg::TIMER_W-1:0] count;
   logic [dcf_pkg::TIMER_W-1:0] next_count;
   logic busy;
   logic next_busy;
   logic next_expired;

   always_comb begin
      next_count = count;
      next_busy = busy;
      next_expired = 1'h0;
      if (i_start) begin
         // doubling per select step keeps the loader a plain shift
         next_count = (dcf_pkg::TIMER_W'(P_BASE_CYC) << i_sel) - ONE;
         next_busy = 1'h1;
      end else if (busy) begin
         if (count == ZERO) begin
            next_busy = 1'h0;
            next_expired = 1'h1;
         end else begin
            next_count = count - ONE;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         count <= ZERO;
         busy <= 1'h0;
         o_expired <= 1'h0;
      end else begin
         count <= next_count;
         busy <= next_busy;
         o_expired <= next_expired;
      end
   end
endmodule : dcf_restart_timer

// ===== logic/dcf_supervisor.sv
// dual channel fault supervisor: status flags, fault recovery, watchdog, fault pin
`timescale 1ns/1ps
module dcf_supervisor #(
   parameter int P_RESTART_BASE_CYC = dcf_pkg::RESTART_BASE_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // analog comparator levels, asynchronous, per channel
   input wire logic [1:0] i_csn_below_thr,
   input wire logic [1:0] i_hs_overcurrent,
   input wire logic [1:0] i_ls_overcurrent,
   input wire logic [1:0] i_at_min_off,
   input wire logic [1:0] i_bst_uv,
   input wire logic [1:0] i_comp_ov,
   input wire logic [1:0] i_over_temp,
   input wire logic [1:0] i_temp_cooled,
   input wire logic [1:0] i_vin_uv,
   // analog comparator levels, asynchronous, shared
   input wire logic i_thermal_warn,
   input wire logic i_analog_supply_uv,
   // spi framing events, same clock
   input wire logic i_spi_frame_valid,
   input wire logic i_spi_frame_error,
   input wire logic [2:0] i_status_rd_end,
   // configuration one write
   input wire logic i_cfg1_wr,
   input wire logic [1:0] i_channel_on_bit,
   input wire logic i_comm_watchdog_on,
   input wire logic i_fault_pin_clear,
   // configuration two write
   input wire logic i_cfg2_wr,
   input wire logic [1:0] i_thermal_latch_select,
   input wire logic [1:0] i_high_side_latch_select,
   input wire logic [1:0] i_low_side_latch_select,
   input wire logic [1:0] i_restart_delay_select,
   input wire logic [4:0] i_watchdog_tap_select,
   // status registers, channel on bits and standalone mode
   output logic [dcf_pkg::ST_W-1:0] o_status_reg_one,
   output logic [dcf_pkg::ST_W-1:0] o_status_reg_two,
   output logic [dcf_pkg::ST_W-1:0] o_status_reg_three,
   output logic [1:0] o_channel_on_bit,
   output logic o_standalone_mode,
   // power stage commands, per channel
   output logic [1:0] o_hs_allow,
   output logic [1:0] o_ls_allow,
   output logic [1:0] o_ls_force_on,
   output logic [1:0] o_comp_discharge,
   output logic [1:0] o_comp_disconnect,
   output logic [1:0] o_soft_start,
   // open drain fault pin
   output logic o_fault_pin_n_out,
   output logic o_fault_pin_n_oe
);
   localparam int NC = dcf_pkg::NUM_CH;
   localparam int CS = dcf_pkg::CH_STRIDE;
   localparam logic [dcf_pkg::WD_W-1:0] WD_ZERO = 25'h0000000;
   localparam logic [dcf_pkg::WD_W-1:0] WD_ONE = 25'h0000001;

   // two stage synchroniser for every comparator level
   logic [dcf_pkg::SY_W-1:0] sync_meta;
   logic [dcf_pkg::SY_W-1:0] sync_q;
   logic [1:0] s_short;
   logic [1:0] s_hs_oc;
   logic [1:0] s_ls_oc;
   logic [1:0] s_min_off;
   logic [1:0] s_bst_uv;
   logic [1:0] s_comp_ov;
   logic [1:0] s_over_temp;
   logic [1:0] s_cooled;
   logic [1:0] s_vin_uv;
   logic s_warn;
   logic s_auv;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync_meta <= '0;
         sync_q <= '0;
      end else begin
         sync_meta <= {i_analog_supply_uv, i_thermal_warn, i_vin_uv, i_temp_cooled,
                       i_over_temp, i_comp_ov, i_bst_uv, i_at_min_off,
                       i_ls_overcurrent, i_hs_overcurrent, i_csn_below_thr};
         sync_q <= sync_meta;
      end
   end

   assign {s_auv, s_warn, s_vin_uv, s_cooled, s_over_temp, s_comp_ov, s_bst_uv,
           s_min_off, s_ls_oc, s_hs_oc, s_short} = sync_q;

   // configuration two fields, plus the watchdog enable from configuration one
   logic [1:0] cfg_tlatch;
   logic [1:0] cfg_hlatch;
   logic [1:0] cfg_llatch;
   logic [1:0] cfg_delay;
   logic [4:0] cfg_tap;
   logic cfg_wd_on;
   logic [1:0] next_tlatch;
   logic [1:0] next_hlatch;
   logic [1:0] next_llatch;
   logic [1:0] next_delay;
   logic [4:0] next_tap;
   logic next_wd_on;

   always_comb begin
      next_tlatch = cfg_tlatch;
      next_hlatch = cfg_hlatch;
      next_llatch = cfg_llatch;
      next_delay = cfg_delay;
      next_tap = cfg_tap;
      next_wd_on = cfg_wd_on;
      if (i_cfg2_wr) begin
         next_tlatch = i_thermal_latch_select;
         next_hlatch = i_high_side_latch_select;
         next_llatch = i_low_side_latch_select;
         next_delay = i_restart_delay_select;
         next_tap = i_watchdog_tap_select;
      end
      if (i_cfg1_wr) begin
         next_wd_on = i_comm_watchdog_on;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_tlatch <= 2'h0;
         cfg_hlatch <= 2'h0;
         cfg_llatch <= 2'h0;
         cfg_delay <= dcf_pkg::RESTART_SEL_RESET;
         cfg_tap <= dcf_pkg::WD_TAP_RESET;
         cfg_wd_on <= dcf_pkg::WD_ON_RESET;
      end else begin
         cfg_tlatch <= next_tlatch;
         cfg_hlatch <= next_hlatch;
         cfg_llatch <= next_llatch;
         cfg_delay <= next_delay;
         cfg_tap <= next_tap;
         cfg_wd_on <= next_wd_on;
      end
   end

   // communication watchdog
   logic [dcf_pkg::WD_W-1:0] wd_cnt;
   logic [dcf_pkg::WD_W-1:0] next_wd_cnt;
   logic next_standalone;
   logic wd_timeout;

   always_comb begin
      next_wd_cnt = wd_cnt;
      next_standalone = o_standalone_mode;
      wd_timeout = 1'h0;
      if (!cfg_wd_on || o_standalone_mode) begin
         next_wd_cnt = WD_ZERO;
      end else if (i_spi_frame_valid) begin
         next_wd_cnt = WD_ZERO;
      end else if ((wd_cnt >> cfg_tap) != WD_ZERO) begin
         // taps at or above the counter width never fire
         wd_timeout = 1'h1;
         next_standalone = 1'h1;
         next_wd_cnt = WD_ZERO;
      end else begin
         next_wd_cnt = wd_cnt + WD_ONE;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         wd_cnt <= WD_ZERO;
         o_standalone_mode <= 1'h0;
      end else begin
         wd_cnt <= next_wd_cnt;
         o_standalone_mode <= next_standalone;
      end
   end

   // per channel recovery state
   logic [1:0] ch_fault_active;

   for (genvar c = 0; c < NC; c++) begin : g_ch
      dcf_pkg::dcf_ch_state_t state;
      dcf_pkg::dcf_ch_state_t next_state;
      logic hs_kind;
      logic next_hs_kind;
      logic next_on;
      logic timer_start;
      logic timer_done;
      logic flags_clear;
      logic run_ok;
      logic next_hs_allow;
      logic next_ls_allow;
      logic next_ls_force;
      logic next_comp_dis;
      logic next_comp_disc;
      logic next_soft;

      dcf_restart_timer #(
         .P_BASE_CYC(P_RESTART_BASE_CYC)
      ) u_timer (
         .i_mclk(i_mclk),
         .i_nrst(i_nrst),
         .i_start(timer_start),
         .i_sel(cfg_delay),
         .o_expired(timer_done)
      );

      assign flags_clear = !o_status_reg_one[c*CS+dcf_pkg::ST1_HS_LIM]
                           && !o_status_reg_one[c*CS+dcf_pkg::ST1_LS_LIM]
                           && !o_status_reg_two[c*CS+dcf_pkg::ST2_THERMAL];
      assign ch_fault_active[c] = s_hs_oc[c] || s_ls_oc[c] || s_over_temp[c]
                                  || state == dcf_pkg::CH_WAIT_TIMER
                                  || state == dcf_pkg::CH_WAIT_COOL
                                  || state == dcf_pkg::CH_LATCHED;

      always_comb begin
         next_state = state;
         next_hs_kind = hs_kind;
         next_on = o_channel_on_bit[c];
         timer_start = 1'h0;
         next_soft = 1'h0;
         if (i_cfg1_wr) begin
            next_on = i_channel_on_bit[c];
         end
         unique case (state)
            dcf_pkg::CH_OFF: begin
               if (o_channel_on_bit[c]) begin
                  next_state = dcf_pkg::CH_RUN;
               end
            end
            dcf_pkg::CH_RUN: begin
               if (!o_channel_on_bit[c]) begin
                  next_state = dcf_pkg::CH_OFF;
               end else if (s_over_temp[c]) begin
                  if (cfg_tlatch[c]) begin
                     next_state = dcf_pkg::CH_LATCHED;
                     next_on = 1'h0;
                  end else begin
                     next_state = dcf_pkg::CH_WAIT_COOL;
                  end
               end else if (s_hs_oc[c] || s_ls_oc[c]) begin
                  next_hs_kind = s_hs_oc[c];
                  if ((s_hs_oc[c] && cfg_hlatch[c]) || (s_ls_oc[c] && cfg_llatch[c])) begin
                     next_state = dcf_pkg::CH_LATCHED;
                     next_on = 1'h0;
                  end else begin
                     next_state = dcf_pkg::CH_WAIT_TIMER;
                     timer_start = 1'h1;
                  end
               end
            end
            dcf_pkg::CH_WAIT_TIMER: begin
               if (!o_channel_on_bit[c]) begin
                  next_state = dcf_pkg::CH_OFF;
               end else if (timer_done) begin
                  next_state = dcf_pkg::CH_RUN;
                  next_soft = 1'h1;
               end
            end
            dcf_pkg::CH_WAIT_COOL: begin
               if (!o_channel_on_bit[c]) begin
                  next_state = dcf_pkg::CH_OFF;
               end else if (s_cooled[c] && !s_over_temp[c]) begin
                  next_state = dcf_pkg::CH_RUN;
                  next_soft = 1'h1;
               end
            end
            dcf_pkg::CH_LATCHED: begin
               // a turn on write is refused while a latching flag is still set
               next_on = 1'h0;
               if (i_cfg1_wr && i_channel_on_bit[c] && flags_clear) begin
                  next_on = 1'h1;
                  next_state = dcf_pkg::CH_RUN;
                  next_soft = 1'h1;
               end
            end
         endcase
         // input undervoltage only gates switching, nothing is recorded
         run_ok = state == dcf_pkg::CH_RUN && !s_vin_uv[c];
         next_hs_allow = run_ok && !s_hs_oc[c] && !s_ls_oc[c] && !s_bst_uv[c]
                         && !s_over_temp[c];
         next_ls_allow = run_ok && !s_ls_oc[c] && !s_over_temp[c];
         next_ls_force = (run_ok && (s_hs_oc[c] || s_bst_uv[c]) && !s_ls_oc[c])
                         || (hs_kind && !s_ls_oc[c] && (state == dcf_pkg::CH_WAIT_TIMER
                         || state == dcf_pkg::CH_LATCHED));
         next_comp_dis = state != dcf_pkg::CH_RUN || s_hs_oc[c] || s_ls_oc[c];
         // follows the min off level in every state so the network is never left cut off
         next_comp_disc = s_min_off[c];
      end

      always_ff @(posedge i_mclk or negedge i_nrst) begin
         if (!i_nrst) begin
            state <= dcf_pkg::CH_OFF;
            hs_kind <= 1'h0;
            o_channel_on_bit[c] <= 1'h0;
            o_hs_allow[c] <= 1'h0;
            o_ls_allow[c] <= 1'h0;
            o_ls_force_on[c] <= 1'h0;
            o_comp_discharge[c] <= 1'h1;
            o_comp_disconnect[c] <= 1'h0;
            o_soft_start[c] <= 1'h0;
         end else begin
            state <= next_state;
            hs_kind <= next_hs_kind;
            o_channel_on_bit[c] <= next_on;
            o_hs_allow[c] <= next_hs_allow;
            o_ls_allow[c] <= next_ls_allow;
            o_ls_force_on[c] <= next_ls_force;
            o_comp_discharge[c] <= next_comp_dis;
            o_comp_disconnect[c] <= next_comp_disc;
            o_soft_start[c] <= next_soft;
         end
      end
   end

   // status flag conditions: a set always beats a read clear in the same cycle
   logic [dcf_pkg::ST_W-1:0] cond1;
   logic [dcf_pkg::ST_W-1:0] cond2;
   logic [dcf_pkg::ST_W-1:0] cond3;
   logic [dcf_pkg::ST_W-1:0] next_st1;
   logic [dcf_pkg::ST_W-1:0] next_st2;
   logic [dcf_pkg::ST_W-1:0] next_st3;

   always_comb begin
      cond1 = '0;
      cond2 = '0;
      cond3 = '0;
      for (int c = 0; c < NC; c++) begin
         cond1[c*CS+dcf_pkg::ST1_SHORT] = s_short[c];
         cond1[c*CS+dcf_pkg::ST1_HS_LIM] = s_hs_oc[c];
         cond1[c*CS+dcf_pkg::ST1_LS_LIM] = s_ls_oc[c];
         cond1[c*CS+dcf_pkg::ST1_COMP_OV] = s_comp_ov[c];
         cond2[c*CS+dcf_pkg::ST2_MIN_OFF] = s_min_off[c];
         cond2[c*CS+dcf_pkg::ST2_BST_UV] = s_bst_uv[c];
         cond2[c*CS+dcf_pkg::ST2_THERMAL] = s_over_temp[c];
      end
      cond3[dcf_pkg::ST3_THERMAL_WARN] = s_warn;
      cond3[dcf_pkg::ST3_ANALOG_UV] = s_auv;
      cond3[dcf_pkg::ST3_SPI_ERROR] = i_spi_frame_error || wd_timeout;
      cond3[dcf_pkg::ST3_LIMP_HOME] = o_standalone_mode;
      next_st1 = (o_status_reg_one & ~({dcf_pkg::ST_W{i_status_rd_end[0]}} & ~cond1))
                 | cond1;
      next_st2 = (o_status_reg_two & ~({dcf_pkg::ST_W{i_status_rd_end[1]}} & ~cond2))
                 | cond2;
      next_st3 = (o_status_reg_three & ~({dcf_pkg::ST_W{i_status_rd_end[2]}} & ~cond3))
                 | cond3;
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_status_reg_one <= dcf_pkg::ST12_RESET;
         o_status_reg_two <= dcf_pkg::ST12_RESET;
         o_status_reg_three <= dcf_pkg::ST3_RESET;
      end else begin
         o_status_reg_one <= next_st1;
         o_status_reg_two <= next_st2;
         o_status_reg_three <= next_st3;
      end
   end

   // fault pin: only current limit and thermal faults, plus the power cycle at reset
   logic fault_event;
   logic next_fpin;

   always_comb begin
      fault_event = |(s_hs_oc | s_ls_oc | s_over_temp);
      next_fpin = o_fault_pin_n_oe;
      if (i_cfg1_wr && i_fault_pin_clear && !(|ch_fault_active)) begin
         next_fpin = 1'h0;
      end
      if (fault_event) begin
         next_fpin = 1'h1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_fault_pin_n_oe <= 1'h1;
         o_fault_pin_n_out <= 1'h0;
      end else begin
         o_fault_pin_n_oe <= next_fpin;
         o_fault_pin_n_out <= 1'h0;
      end
   end
endmodule : dcf_supervisor

// ===== sim/dcf_supervisor_props.sv
// checker on the fault supervisor ports
`timescale 1ns/1ps
module dcf_supervisor_props (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // stimulus seen
   input wire logic [1:0] i_csn_below_thr,
   input wire logic [1:0] i_hs_overcurrent,
   input wire logic [1:0] i_ls_overcurrent,
   input wire logic [1:0] i_at_min_off,
   input wire logic [2:0] i_status_rd_end,
   input wire logic i_cfg1_wr,
   input wire logic i_fault_pin_clear,
   // design outputs
   input wire logic [dcf_pkg::ST_W-1:0] o_status_reg_one,
   input wire logic [dcf_pkg::ST_W-1:0] o_status_reg_two,
   input wire logic [dcf_pkg::ST_W-1:0] o_status_reg_three,
   input wire logic o_standalone_mode,
   input wire logic [1:0] o_hs_allow,
   input wire logic [1:0] o_ls_allow,
   input wire logic [1:0] o_comp_discharge,
   input wire logic [1:0] o_comp_disconnect,
   input wire logic [1:0] o_soft_start,
   input wire logic o_fault_pin_n_out,
   input wire logic o_fault_pin_n_oe
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   // windows allow for the two synchroniser stages on comparator inputs
   a_short_flag_set: assert property ($rose(i_csn_below_thr[0]) |-> ##[2:4] o_status_reg_one[0])
      else $error("short flag not set");
   a_hs_flag_ch1: assert property ($rose(i_hs_overcurrent[1]) |-> ##[2:4] o_status_reg_one[5])
      else $error("high side flag of channel one not set");
   a_ls_both_off: assert property ($rose(i_ls_overcurrent[1]) |-> ##[2:5]
      (!o_hs_allow[1] && !o_ls_allow[1] && o_comp_discharge[1]))
      else $error("low side fault left a switch allowed");
   a_comp_disconnect: assert property (i_at_min_off[0] [*4] |-> o_comp_disconnect[0])
      else $error("comp not disconnected at min off time");
   a_comp_reconnect: assert property (!i_at_min_off[0] [*4] |-> !o_comp_disconnect[0])
      else $error("comp not reconnected");
   a_flag_sticky: assert property (o_status_reg_one[1] && !i_status_rd_end[0]
      |=> o_status_reg_one[1])
      else $error("flag dropped without read");
   a_read_clears: assert property (!i_csn_below_thr[0] [*4] ##0 i_status_rd_end[0]
      |=> !o_status_reg_one[0])
      else $error("read did not clear absent condition");
   a_flag_kept: assert property (i_at_min_off[0] [*4] ##0 i_status_rd_end[1]
      |=> o_status_reg_two[0])
      else $error("read cleared present condition");
   a_hs_pin_low: assert property ($rose(i_hs_overcurrent[0]) |-> ##[2:4]
      (o_fault_pin_n_oe && !o_fault_pin_n_out))
      else $error("fault pin not pulled low");
   a_pin_refuse: assert property (i_hs_overcurrent[0] [*4] ##0 (i_cfg1_wr && i_fault_pin_clear)
      |=> o_fault_pin_n_oe)
      else $error("fault pin released during fault");
   a_standalone_hold: assert property (o_standalone_mode |=> o_standalone_mode)
      else $error("standalone mode left");
   a_limp_flag: assert property ($rose(o_standalone_mode) |-> ##[0:2] o_status_reg_three[4])
      else $error("limp home flag not set");
   c_standalone: cover property ($rose(o_standalone_mode));
   c_restart: cover property (o_soft_start[0]);
   c_hs_flag: cover property (o_status_reg_one[5]);
endmodule : dcf_supervisor_props

bind dcf_supervisor dcf_supervisor_props u_props (.i_mclk, .i_nrst, .i_csn_below_thr,
   .i_hs_overcurrent, .i_ls_overcurrent, .i_at_min_off, .i_status_rd_end, .i_cfg1_wr,
   .i_fault_pin_clear, .o_status_reg_one, .o_status_reg_two, .o_status_reg_three,
   .o_standalone_mode, .o_hs_allow, .o_ls_allow, .o_comp_discharge, .o_comp_disconnect,
   .o_soft_start, .o_fault_pin_n_out, .o_fault_pin_n_oe);

// ===== sim/dcf_host_model.sv
// host side model: fault pin pull-up and spi keep-alive frames
`timescale 1ns/1ps
module dcf_host_model (
   // clock and control
   input wire logic i_mclk,
   input wire logic i_keep_alive,
   // fault pin driver of the device
   input wire logic i_pin_out,
   input wire logic i_pin_oe,
   // seen by the bench
   output logic o_fault_pin_n,
   output logic o_frame_valid
);
   logic [3:0] tick = 4'h0;
   // external pull-up: a released pin reads high
   assign o_fault_pin_n = i_pin_oe ? i_pin_out : 1'b1;
   // a frame every 16 cycles keeps short watchdog taps from expiring
   always @(negedge i_mclk) begin
      tick <= tick + 4'h1;
      o_frame_valid <= i_keep_alive && (tick == 4'h0);
   end
endmodule : dcf_host_model

// ===== sim/tb_dcf_supervisor.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
module tb_dcf_supervisor;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic [19:0] ain = 20'h00000;
   logic i_spi_frame_error = 1'b0, i_cfg1_wr = 1'b0, i_fault_pin_clear = 1'b0;
   logic i_cfg2_wr = 1'b0, keep = 1'b1, wdon = 1'b1, pin, i_spi_frame_valid;
   logic [2:0] i_status_rd_end = 3'h0;
   logic [1:0] i_channel_on_bit = 2'h0, dly = 2'h0;
   logic [5:0] lat = 6'h00;
   logic [4:0] tap = 5'h18;
   logic [7:0] o_status_reg_one, o_status_reg_two, o_status_reg_three;
   logic [1:0] o_channel_on_bit, o_hs_allow, o_ls_allow, o_ls_force_on;
   logic [1:0] o_comp_discharge, o_comp_disconnect, o_soft_start;
   logic o_standalone_mode, o_fault_pin_n_out, o_fault_pin_n_oe;
   int mismatches = 0, tests_run = 0, n;
   // async bits: csn 1:0 hs 3:2 ls 5:4 minoff 7:6 bst 9:8 compov 11:10 temp 13:12
   // cooled 15:14 vinuv 17:16 warn 18 auv 19; expected {st1,st2,st3}
   logic [43:0] rows [17] = '{44'h00001_010000, 44'h00002_100000, 44'h00004_020000,
      44'h00008_200000, 44'h00010_040000, 44'h00020_400000, 44'h00040_000100,
      44'h00080_001000, 44'h00100_000200, 44'h00200_002000, 44'h00400_080000,
      44'h00800_800000, 44'h01000_000400, 44'h02000_004000, 44'h30000_000000,
      44'h40000_000001, 44'h80000_000002};
   dcf_supervisor #(.P_RESTART_BASE_CYC(20)) u_dut (.i_mclk, .i_nrst,
      .i_csn_below_thr(ain[1:0]), .i_hs_overcurrent(ain[3:2]), .i_ls_overcurrent(ain[5:4]),
      .i_at_min_off(ain[7:6]), .i_bst_uv(ain[9:8]), .i_comp_ov(ain[11:10]),
      .i_over_temp(ain[13:12]), .i_temp_cooled(ain[15:14]), .i_vin_uv(ain[17:16]),
      .i_thermal_warn(ain[18]), .i_analog_supply_uv(ain[19]), .i_spi_frame_valid,
      .i_spi_frame_error, .i_status_rd_end, .i_cfg1_wr, .i_channel_on_bit,
      .i_comm_watchdog_on(wdon), .i_fault_pin_clear, .i_cfg2_wr,
      .i_thermal_latch_select(lat[5:4]), .i_high_side_latch_select(lat[3:2]),
      .i_low_side_latch_select(lat[1:0]), .i_restart_delay_select(dly),
      .i_watchdog_tap_select(tap), .o_status_reg_one, .o_status_reg_two,
      .o_status_reg_three, .o_channel_on_bit, .o_standalone_mode, .o_hs_allow, .o_ls_allow,
      .o_ls_force_on, .o_comp_discharge, .o_comp_disconnect, .o_soft_start,
      .o_fault_pin_n_out, .o_fault_pin_n_oe);
   dcf_host_model u_host (.i_mclk, .i_keep_alive(keep), .i_pin_out(o_fault_pin_n_out),
      .i_pin_oe(o_fault_pin_n_oe), .o_fault_pin_n(pin), .o_frame_valid(i_spi_frame_valid));
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(negedge i_mclk);
   endtask : tick
   task automatic cfg1(input logic [1:0] on, input logic clr);
      i_channel_on_bit = on;
      i_fault_pin_clear = clr;
      i_cfg1_wr = 1'b1;
      tick(1);
      i_cfg1_wr = 1'b0;
   endtask : cfg1
   task automatic cfg2(input logic [5:0] l, input logic [1:0] d, input logic [4:0] t);
      lat = l;
      dly = d;
      tap = t;
      i_cfg2_wr = 1'b1;
      tick(1);
      i_cfg2_wr = 1'b0;
   endtask : cfg2
   task automatic rd(input logic [2:0] m);
      i_status_rd_end = m;
      tick(1);
      i_status_rd_end = 3'h0;
   endtask : rd
   // bounded wait for the restart pulse of channel c
   task automatic wait_ss(input int c, output int k);
      k = 0;
      while (o_soft_start[c] !== 1'b1 && k < 2000) begin
         tick(1);
         k++;
      end
   endtask : wait_ss
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   initial forever #20 i_mclk = ~i_mclk;
   initial begin
      #400us;
      mismatches++;
      print_verdict();
   end
   initial begin
      tick(20);
      i_nrst = 1'b1;
      check("reset st", {o_status_reg_one, o_status_reg_two, o_status_reg_three}, 24'h4);
      check("reset pin", pin, 1'b0);
      check("reset disc", o_comp_discharge, 2'h3);
      cfg1(2'h0, 1'b1);
      rd(3'h4);
      tick(1);
      check("pin free", pin, 1'b1);
      for (int k = 0; k < 17; k++) begin
         ain = rows[k][43:24];
         tick(5);
         check("flags", {o_status_reg_one, o_status_reg_two, o_status_reg_three}, rows[k][23:0]);
         ain = 20'h0;
         tick(5);
         rd(3'h7);
         tick(1);
         check("cleared", {o_status_reg_one, o_status_reg_two, o_status_reg_three}, 24'h0);
      end
      cfg1(2'h0, 1'b1);
      tick(1);
      check("pin free", pin, 1'b1);
      ain = 20'hF0541;
      tick(5);
      check("no pin", pin, 1'b1);
      check("disc", o_comp_disconnect, 2'h1);
      ain = 20'h00044;
      tick(5);
      rd(3'h3);
      tick(1);
      check("kept", {o_status_reg_one[1], o_status_reg_two[0]}, 2'h3);
      cfg1(2'h0, 1'b1);
      tick(2);
      check("pin held", pin, 1'b0);
      ain = 20'h0;
      tick(5);
      rd(3'h7);
      cfg1(2'h0, 1'b1);
      tick(2);
      check("pin free", pin, 1'b1);
      cfg2(6'h00, 2'h1, 5'h18);
      cfg1(2'h3, 1'b0);
      tick(5);
      check("run", o_hs_allow, 2'h3);
      ain = 20'h00004;
      tick(3);
      ain = 20'h0;
      tick(3);
      check("hs off", o_hs_allow, 2'h2);
      check("hs fault", {o_ls_force_on[0], o_comp_discharge[0]}, 2'h3);
      wait_ss(0, n);
      check("delay", (n >= 32 && n <= 44), 1'b1);
      tick(2);
      check("resumed", o_hs_allow[0], 1'b1);
      ain = 20'h00020;
      tick(6);
      ain = 20'h0;
      check("ls off", {o_hs_allow[1], o_ls_allow[1], o_comp_discharge[1]}, 3'h1);
      wait_ss(1, n);
      rd(3'h7);
      cfg2(6'h04, 2'h0, 5'h18);
      ain = 20'h00004;
      tick(4);
      ain = 20'h0;
      tick(60);
      check("latched", {o_channel_on_bit[0], o_hs_allow[0]}, 2'h0);
      cfg1(2'h3, 1'b0);
      tick(3);
      check("refused", o_channel_on_bit[0], 1'b0);
      rd(3'h1);
      cfg1(2'h3, 1'b0);
      tick(4);
      check("relit", o_hs_allow[0], 1'b1);
      cfg2(6'h00, 2'h0, 5'h18);
      ain = 20'h02000;
      tick(6);
      check("hot", o_hs_allow[1], 1'b0);
      ain = 20'h08000;
      wait_ss(1, n);
      ain = 20'h0;
      tick(2);
      check("cooled", {(n < 2000), o_hs_allow[1]}, 2'h3);
      i_spi_frame_error = 1'b1;
      tick(1);
      i_spi_frame_error = 1'b0;
      tick(2);
      check("spi err", o_status_reg_three[3], 1'b1);
      rd(3'h4);
      cfg2(6'h00, 2'h0, 5'h05);
      tick(100);
      check("fed", o_standalone_mode, 1'b0);
      @(posedge i_spi_frame_valid);
      tick(1);
      keep = 1'b0;
      n = 0;
      while (o_standalone_mode !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      check("timeout", (n >= 30 && n <= 38), 1'b1);
      tick(2);
      check("limp", o_status_reg_three[4:3], 2'h3);
      i_nrst = 1'b0;
      tick(3);
      i_nrst = 1'b1;
      tick(1);
      check("re-reset", {o_standalone_mode, o_status_reg_three}, 9'h004);
      wdon = 1'b0;
      cfg1(2'h0, 1'b0);
      cfg2(6'h00, 2'h0, 5'h05);
      tick(60);
      check("wd off", o_standalone_mode, 1'b0);
      print_verdict();
   end
endmodule : tb_dcf_supervisor
